// ### design/trig_ctrl_pkg.sv
// Purpose: shared constants for the master trigger control block
// Assumes: 32-bit register port, byte addresses, one aligned word per register
// Notes: control word offset and field layout live here only
package trig_ctrl_pkg;

	// =====================================================================
	// bus geometry, channel and pin counts
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CH_NUM = 4;
	localparam int PIN_NUM = 3;

	// =====================================================================
	// master control register
	localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h04;
	localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [DATA_W-1:0] READ_IDLE = 32'h0000_0000;
	localparam int XOR_SEL_BIT = 7;
	localparam int TSEL_MSB = 6;
	localparam int TSEL_LSB = 4;
	localparam int DMA_SEL_BIT = 3;
	// compare selections carry this bit set, low two bits pick the channel
	localparam int TSEL_CMP_BIT = 2;

	// =====================================================================
	// trigger output selections
	typedef enum logic [2:0] {
		TSEL_RESET = 3'h0,
		TSEL_ENABLE = 3'h1,
		TSEL_UPDATE = 3'h2,
		TSEL_CCPULSE = 3'h3,
		TSEL_CMP1 = 3'h4,
		TSEL_CMP2 = 3'h5,
		TSEL_CMP3 = 3'h6,
		TSEL_CMP4 = 3'h7
	} trig_sel_t;

endpackage

// ### design/pin_sync.sv
// Purpose: three-stage synchroniser with agreement check for one pin
// Assumes: pin is asynchronous to the timer clock
// Notes: output changes once stages two and three agree
`timescale 1ns/1ps
module pin_sync (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// pin and filtered level
	input wire logic din,
	output logic dout
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic q;
	} sync_t;

	sync_t s_r;
	sync_t s_nxt;

	// =====================================================================
	// next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.s1 = din;
		// first stage feeds only the second, never the compare
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
		if (s_r.s2 == s_r.s3) begin
			s_nxt.q = s_r.s3;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign dout = s_r.q;

endmodule

// ### design/timer_master_trigger_control.sv
// Purpose: master trigger output, channel 1 input select and DMA source select
// Assumes: timer-side strobes are one-cycle pulses on SYS_CLK; pins are asynchronous
// Notes: control word at CTRL_OFFSET; reserved bits read zero and ignore writes
// Function
// - select bit 0 routes first channel pin to channel 1 trigger input.
// - select bit 1 routes XOR of first three channel pins instead.
// - reset selection pulses output on update-generate or slave-controller reset.
// - slave-reset pulse comes one cycle later than an update-generate pulse.
// - enable selection drives output from the counter enable signal.
// - counter enable is counter run or pause-mode trigger input high.
// - pause input is delayed a cycle unless master-slave mode is on.
// - update selection drives output from the update event.
// - capture/compare selection pulses output on first channel capture or match.
// - compare selections drive output from compare reference one to four.
// - DMA source bit 0 gives per-channel requests on capture/compare events.
// - DMA source bit 1 gives all channel requests on update event.
`timescale 1ns/1ps
module timer_master_trigger_control
	import trig_ctrl_pkg::*;
(
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic NRST,
	// register port
	input wire logic [ADDR_W-1:0] REG_ADDR,
	input wire logic [DATA_W-1:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [DATA_W-1:0] REG_RDATA,
	// counter core and slave controller
	input wire logic UPDATE_GENERATE,
	input wire logic SLAVE_RESET,
	input wire logic COUNTER_RUN,
	input wire logic PAUSE_TRIGGER,
	input wire logic MASTER_SLAVE_MODE,
	input wire logic UPDATE_EVENT,
	// capture/compare channels
	input wire logic [CH_NUM-1:0] CC_EVENT,
	input wire logic FIRST_COMPARE_REF,
	input wire logic SECOND_COMPARE_REF,
	input wire logic THIRD_COMPARE_REF,
	input wire logic FOURTH_COMPARE_REF,
	// channel pins
	input wire logic FIRST_CHANNEL_PIN,
	input wire logic SECOND_CHANNEL_PIN,
	input wire logic THIRD_CHANNEL_PIN,
	// outputs
	output logic SYNC_TRIGGER_OUTPUT,
	output logic FIRST_TRIGGER_INPUT,
	output logic [CH_NUM-1:0] DMA_REQUEST
);

	typedef struct packed {
		logic xor_sel;
		trig_sel_t trig_sel;
		logic dma_sel;
		logic rst_d;
		logic pause_d;
		logic rst_ev_p;
		logic cc_ev_p;
		logic trg;
		logic ti1;
		logic [CH_NUM-1:0] dma;
		logic [DATA_W-1:0] rdata;
	} state_t;

	localparam state_t ST_RESET = '{
		xor_sel: CTRL_RESET[XOR_SEL_BIT],
		trig_sel: trig_sel_t'(CTRL_RESET[TSEL_MSB:TSEL_LSB]),
		dma_sel: CTRL_RESET[DMA_SEL_BIT],
		rst_d: 1'b0,
		pause_d: 1'b0,
		rst_ev_p: 1'b0,
		cc_ev_p: 1'b0,
		trg: 1'b0,
		ti1: 1'b0,
		dma: '0,
		rdata: READ_IDLE
	};

	state_t s_r;
	state_t s_nxt;

	// =====================================================================
	// decoding helpers
	function automatic logic ctrl_hit(input logic [ADDR_W-1:0] addr);
		ctrl_hit = (addr == CTRL_OFFSET);
	endfunction

	function automatic logic [DATA_W-1:0] ctrl_word(input state_t st);
		logic [DATA_W-1:0] w;
		w = '0;
		w[XOR_SEL_BIT] = st.xor_sel;
		w[TSEL_MSB:TSEL_LSB] = st.trig_sel;
		w[DMA_SEL_BIT] = st.dma_sel;
		ctrl_word = w;
	endfunction

	// =====================================================================
	// pin synchronisers
	logic [PIN_NUM-1:0] pin_raw;
	logic [PIN_NUM-1:0] pin_q;

	assign pin_raw = {THIRD_CHANNEL_PIN, SECOND_CHANNEL_PIN, FIRST_CHANNEL_PIN};

	genvar g;
	generate
		for (g = 0; g < PIN_NUM; g++) begin : g_pin
			pin_sync u_sync (
				.clk(SYS_CLK),
				.rst_n(NRST),
				.din(pin_raw[g]),
				.dout(pin_q[g])
			);
		end
	endgenerate

	// =====================================================================
	// event terms
	logic rst_ev;
	logic cc_ev;
	logic pause_eff;
	logic cnt_enable;
	logic cmp_sel;
	logic [CH_NUM-1:0] cmp_ref;

	assign cmp_ref = {FOURTH_COMPARE_REF, THIRD_COMPARE_REF, SECOND_COMPARE_REF, FIRST_COMPARE_REF};
	// slave reset goes through rst_d so its pulse trails the counter reset
	assign rst_ev = UPDATE_GENERATE | s_r.rst_d;
	assign cc_ev = CC_EVENT[0];
	// master-slave mode bypasses the pause delay
	assign pause_eff = MASTER_SLAVE_MODE ? PAUSE_TRIGGER : s_r.pause_d;
	assign cnt_enable = COUNTER_RUN | pause_eff;
	assign cmp_sel = cmp_ref[s_r.trig_sel[1:0]];

	// =====================================================================
	// next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.rst_d = SLAVE_RESET;
		s_nxt.pause_d = PAUSE_TRIGGER;
		s_nxt.rst_ev_p = rst_ev;
		s_nxt.cc_ev_p = cc_ev;

		// edge qualify pulse sources so a held event gives one pulse
		case (s_r.trig_sel)
			TSEL_RESET: begin
				s_nxt.trg = rst_ev & ~s_r.rst_ev_p;
			end
			TSEL_ENABLE: begin
				s_nxt.trg = cnt_enable;
			end
			TSEL_UPDATE: begin
				s_nxt.trg = UPDATE_EVENT;
			end
			TSEL_CCPULSE: begin
				s_nxt.trg = cc_ev & ~s_r.cc_ev_p;
			end
			default: begin
				s_nxt.trg = cmp_sel;
			end
		endcase

		if (s_r.xor_sel) begin
			s_nxt.ti1 = ^pin_q;
		end else begin
			s_nxt.ti1 = pin_q[0];
		end

		if (s_r.dma_sel) begin
			s_nxt.dma = {CH_NUM{UPDATE_EVENT}};
		end else begin
			s_nxt.dma = CC_EVENT;
		end

		// reserved bits are not stored, so a stray write cannot stick
		if (REG_WR && ctrl_hit(REG_ADDR)) begin
			s_nxt.xor_sel = REG_WDATA[XOR_SEL_BIT];
			s_nxt.trig_sel = trig_sel_t'(REG_WDATA[TSEL_MSB:TSEL_LSB]);
			s_nxt.dma_sel = REG_WDATA[DMA_SEL_BIT];
		end

		// read data stand one cycle only; unmapped reads give zero
		s_nxt.rdata = READ_IDLE;
		if (REG_RD && ctrl_hit(REG_ADDR)) begin
			s_nxt.rdata = ctrl_word(s_r);
		end
	end

	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			s_r <= ST_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign REG_RDATA = s_r.rdata;
	assign SYNC_TRIGGER_OUTPUT = s_r.trg;
	assign FIRST_TRIGGER_INPUT = s_r.ti1;
	assign DMA_REQUEST = s_r.dma;

	// =====================================================================
	// assertions
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!NRST);

	logic wr_ctrl;
	assign wr_ctrl = REG_WR && ctrl_hit(REG_ADDR);

	property p_direct_pin;
		!s_r.xor_sel |=> FIRST_TRIGGER_INPUT == $past(pin_q[0]);
	endproperty
	a_direct_pin: assert property (p_direct_pin) else $error("channel 1 input not the first pin");

	property p_xor_pins;
		s_r.xor_sel |=> FIRST_TRIGGER_INPUT == ($past(pin_q[0]) ^ $past(pin_q[1]) ^ $past(pin_q[2]));
	endproperty
	a_xor_pins: assert property (p_xor_pins) else $error("channel 1 input not the pin xor");

	// writable field positions; everything else reads zero
	localparam logic [DATA_W-1:0] CTRL_MASK = ctrl_word('1);

	property p_gen_pulse;
		(s_r.trig_sel == TSEL_RESET && UPDATE_GENERATE && !s_r.rst_ev_p) |=> SYNC_TRIGGER_OUTPUT;
	endproperty
	a_gen_pulse: assert property (p_gen_pulse) else $error("no trigger pulse after update generate");

	sequence s_slave_rst;
		s_r.trig_sel == TSEL_RESET && SLAVE_RESET && !UPDATE_GENERATE && !s_r.rst_d && !s_r.rst_ev_p;
	endsequence

	sequence s_still_reset;
		s_r.trig_sel == TSEL_RESET && !wr_ctrl;
	endsequence

	property p_slave_not_same;
		(s_r.trig_sel == TSEL_RESET && SLAVE_RESET && !UPDATE_GENERATE && !s_r.rst_d) |=> !SYNC_TRIGGER_OUTPUT;
	endproperty
	a_slave_not_same: assert property (p_slave_not_same) else $error("slave reset pulse in same cycle");

	property p_slave_rst_late;
		s_slave_rst ##1 s_still_reset |-> !SYNC_TRIGGER_OUTPUT ##1 SYNC_TRIGGER_OUTPUT;
	endproperty
	a_slave_rst_late: assert property (p_slave_rst_late) else $error("slave reset pulse not one cycle late");

	property p_single_pulse;
		(SYNC_TRIGGER_OUTPUT && (s_r.trig_sel == TSEL_RESET || s_r.trig_sel == TSEL_CCPULSE) && $stable(s_r.trig_sel))
			|=> !SYNC_TRIGGER_OUTPUT;
	endproperty
	a_single_pulse: assert property (p_single_pulse) else $error("trigger pulse longer than one cycle");

	property p_enable_run;
		(s_r.trig_sel == TSEL_ENABLE && COUNTER_RUN) |=> SYNC_TRIGGER_OUTPUT;
	endproperty
	a_enable_run: assert property (p_enable_run) else $error("enable selection ignores counter run");

	property p_enable_idle;
		(s_r.trig_sel == TSEL_ENABLE && !COUNTER_RUN && !PAUSE_TRIGGER && !s_r.pause_d) |=> !SYNC_TRIGGER_OUTPUT;
	endproperty
	a_enable_idle: assert property (p_enable_idle) else $error("enable selection high with no cause");

	sequence s_pause_rise;
		s_r.trig_sel == TSEL_ENABLE && !COUNTER_RUN && !MASTER_SLAVE_MODE && PAUSE_TRIGGER && !s_r.pause_d;
	endsequence

	property p_pause_delay;
		s_pause_rise ##1 (s_r.trig_sel == TSEL_ENABLE && !wr_ctrl && !MASTER_SLAVE_MODE)
			|-> !SYNC_TRIGGER_OUTPUT ##1 SYNC_TRIGGER_OUTPUT;
	endproperty
	a_pause_delay: assert property (p_pause_delay) else $error("pause input not delayed by one cycle");

	property p_pause_direct;
		(s_r.trig_sel == TSEL_ENABLE && MASTER_SLAVE_MODE && PAUSE_TRIGGER) |=> SYNC_TRIGGER_OUTPUT;
	endproperty
	a_pause_direct: assert property (p_pause_direct) else $error("master-slave pause not direct");

	property p_update_sel;
		s_r.trig_sel == TSEL_UPDATE |=> SYNC_TRIGGER_OUTPUT == $past(UPDATE_EVENT);
	endproperty
	a_update_sel: assert property (p_update_sel) else $error("update selection mismatch");

	property p_cc_pulse;
		(s_r.trig_sel == TSEL_CCPULSE && CC_EVENT[0] && !s_r.cc_ev_p) |=> SYNC_TRIGGER_OUTPUT;
	endproperty
	a_cc_pulse: assert property (p_cc_pulse) else $error("no pulse on first channel event");

	property p_cmp_sel;
		s_r.trig_sel[TSEL_CMP_BIT] |=> SYNC_TRIGGER_OUTPUT == $past(cmp_sel);
	endproperty
	a_cmp_sel: assert property (p_cmp_sel) else $error("compare reference selection mismatch");

	// each compare selection against its own pin, not the shared mux
	property p_cmp_first;
		s_r.trig_sel == TSEL_CMP1 |=> SYNC_TRIGGER_OUTPUT == $past(FIRST_COMPARE_REF);
	endproperty
	a_cmp_first: assert property (p_cmp_first) else $error("trigger not first compare reference");

	property p_cmp_second;
		s_r.trig_sel == TSEL_CMP2 |=> SYNC_TRIGGER_OUTPUT == $past(SECOND_COMPARE_REF);
	endproperty
	a_cmp_second: assert property (p_cmp_second) else $error("trigger not second compare reference");

	property p_cmp_third;
		s_r.trig_sel == TSEL_CMP3 |=> SYNC_TRIGGER_OUTPUT == $past(THIRD_COMPARE_REF);
	endproperty
	a_cmp_third: assert property (p_cmp_third) else $error("trigger not third compare reference");

	property p_cmp_fourth;
		s_r.trig_sel == TSEL_CMP4 |=> SYNC_TRIGGER_OUTPUT == $past(FOURTH_COMPARE_REF);
	endproperty
	a_cmp_fourth: assert property (p_cmp_fourth) else $error("trigger not fourth compare reference");

	property p_dma_cc;
		!s_r.dma_sel |=> DMA_REQUEST == $past(CC_EVENT);
	endproperty
	a_dma_cc: assert property (p_dma_cc) else $error("DMA request not on capture/compare");

	property p_dma_upd;
		s_r.dma_sel |=> DMA_REQUEST == {CH_NUM{$past(UPDATE_EVENT)}};
	endproperty
	a_dma_upd: assert property (p_dma_upd) else $error("DMA request not on update event");

	property p_write_read;
		(wr_ctrl ##1 (REG_RD && ctrl_hit(REG_ADDR) && !REG_WR))
			|=> REG_RDATA == ($past(REG_WDATA, 2) & CTRL_MASK);
	endproperty
	a_write_read: assert property (p_write_read) else $error("control readback wrong or reserved bits set");

	property p_write_take;
		wr_ctrl |=> ctrl_word(s_r) == ($past(REG_WDATA) & CTRL_MASK);
	endproperty
	a_write_take: assert property (p_write_take) else $error("control write not taken");

	property p_ctrl_hold;
		!wr_ctrl |=> $stable(s_r.xor_sel) && $stable(s_r.trig_sel) && $stable(s_r.dma_sel);
	endproperty
	a_ctrl_hold: assert property (p_ctrl_hold) else $error("control word changed without a write");

	property p_read_reserved;
		(REG_RDATA & ~CTRL_MASK) == '0;
	endproperty
	a_read_reserved: assert property (p_read_reserved) else $error("reserved bits read as one");

	property p_read_idle;
		!$past(REG_RD) |-> REG_RDATA == READ_IDLE;
	endproperty
	a_read_idle: assert property (p_read_idle) else $error("read data outside the read cycle");

endmodule

// ### testbench/slave_timer_model.sv
// Purpose: slave timer stand-in that counts starts from the master trigger
// Assumes: trigger is a registered level on the timer clock
// Notes: a start is a low-to-high edge, so a stuck-high trigger counts once
`timescale 1ns/1ps
module slave_timer_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// trigger from master
	input wire logic trig,
	output logic [7:0] starts
);
	// =====================================
	// start counter
	typedef struct packed {logic last; logic [7:0] cnt;} slv_t;
	slv_t st_r, st_nxt;
	always_comb begin
		st_nxt = st_r;
		st_nxt.last = trig;
		if (trig && !st_r.last) st_nxt.cnt = st_r.cnt + 8'h01;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) st_r <= '0;
		else st_r <= st_nxt;
	end
	assign starts = st_r.cnt;
endmodule

// ### testbench/timer_master_trigger_control_tb_top.sv
// Purpose: directed bench for the master trigger control block
// Assumes: inputs change by non-blocking assignment at rising edges
// Notes: outputs are sampled at falling edges, clear of update races, except the reset check and the starts baseline
`timescale 1ns/1ps
module timer_master_trigger_control_tb_top import trig_ctrl_pkg::*;;
	logic clk, rst_n, wr, rd, upd_gen, srst, run, pause, msm, upd, sync_trg, ti1;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata;
	logic [CH_NUM-1:0] cc, cref, dma;
	logic [PIN_NUM-1:0] pins;
	logic [7:0] starts;
	int miscompares = 0;
	int check_count = 0;

	// =====================================
	// design and far side
	timer_master_trigger_control i_timer_master_trigger_control (.SYS_CLK(clk), .NRST(rst_n),
		.REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
		.UPDATE_GENERATE(upd_gen), .SLAVE_RESET(srst), .COUNTER_RUN(run), .PAUSE_TRIGGER(pause),
		.MASTER_SLAVE_MODE(msm), .UPDATE_EVENT(upd), .CC_EVENT(cc),
		.FIRST_COMPARE_REF(cref[0]), .SECOND_COMPARE_REF(cref[1]),
		.THIRD_COMPARE_REF(cref[2]), .FOURTH_COMPARE_REF(cref[3]),
		.FIRST_CHANNEL_PIN(pins[0]), .SECOND_CHANNEL_PIN(pins[1]), .THIRD_CHANNEL_PIN(pins[2]),
		.SYNC_TRIGGER_OUTPUT(sync_trg), .FIRST_TRIGGER_INPUT(ti1), .DMA_REQUEST(dma));
	slave_timer_model i_slave_timer_model (.clk(clk), .rst_n(rst_n), .trig(sync_trg), .starts(starts));

	// =====================================
	// helpers
	task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic see(string name, logic e);
		@(negedge clk);
		chk(name, {31'h0, e}, {31'h0, sync_trg});
	endtask
	task automatic wr_reg(logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(logic [7:0] a, logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk("rdata", e, rdata);
	endtask
	function automatic logic [31:0] cw(logic x, logic [2:0] m, logic d);
		return {24'h0, x, m, d, 3'h0};
	endfunction
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// =====================================
	// scenarios
	task automatic t_regs;
		rd_chk(CTRL_OFFSET, 32'h0);
		wr_reg(CTRL_OFFSET, 32'hFFFF_FFFF);
		rd_chk(CTRL_OFFSET, 32'h0000_00F8);
		wr_reg(8'h08, 32'h0);
		rd_chk(CTRL_OFFSET, 32'h0000_00F8);
		rd_chk(8'h08, 32'h0);
	endtask
	task automatic t_pins;
		for (int s = 0; s < 2; s++) begin
			wr_reg(CTRL_OFFSET, cw(s[0], 3'h0, 1'b0));
			for (int p = 0; p < 8; p++) begin
				@(posedge clk);
				pins <= p[2:0];
				repeat (8) @(negedge clk);
				chk("ti1", (s == 1) ? ^p[2:0] : p[0], ti1);
			end
		end
	endtask
	task automatic t_reset_sel;
		wr_reg(CTRL_OFFSET, cw(1'b0, 3'h0, 1'b0));
		@(posedge clk);
		upd_gen <= 1'b1;
		@(posedge clk);
		upd_gen <= 1'b0;
		see("upd_gen", 1'b1);
		see("upd_gen", 1'b0);
		@(posedge clk);
		srst <= 1'b1;
		@(posedge clk);
		srst <= 1'b0;
		see("srst", 1'b0);
		see("srst", 1'b1);
		see("srst", 1'b0);
	endtask
	task automatic t_enable;
		wr_reg(CTRL_OFFSET, cw(1'b0, 3'h1, 1'b0));
		@(posedge clk);
		run <= 1'b1;
		@(posedge clk);
		run <= 1'b0;
		see("run", 1'b1);
		see("run", 1'b0);
		@(posedge clk);
		pause <= 1'b1;
		@(posedge clk);
		pause <= 1'b0;
		see("pause", 1'b0);
		see("pause", 1'b1);
		@(posedge clk);
		msm <= 1'b1;
		pause <= 1'b1;
		@(posedge clk);
		pause <= 1'b0;
		see("msm", 1'b1);
		see("msm", 1'b0);
		@(posedge clk);
		msm <= 1'b0;
	endtask
	task automatic t_upd_cc;
		logic [7:0] n;
		wr_reg(CTRL_OFFSET, cw(1'b0, 3'h2, 1'b0));
		@(posedge clk);
		upd <= 1'b1;
		@(posedge clk);
		upd <= 1'b0;
		see("upd", 1'b1);
		see("upd", 1'b0);
		wr_reg(CTRL_OFFSET, cw(1'b0, 3'h3, 1'b0));
		n = starts;
		@(posedge clk);
		cc <= 4'h1;
		@(posedge clk);
		see("cc", 1'b1);
		see("cc", 1'b0);
		@(posedge clk);
		cc <= 4'h0;
		see("cc", 1'b0);
		chk("starts", n + 8'h01, starts);
	endtask
	task automatic t_compare;
		for (int m = 4; m < 8; m++) begin
			wr_reg(CTRL_OFFSET, cw(1'b0, m[2:0], 1'b0));
			for (int v = 0; v < 2; v++) begin
				@(posedge clk);
				cref <= (v == 1) ? (4'h1 << (m - 4)) : ~(4'h1 << (m - 4));
				@(posedge clk);
				see("cref", v[0]);
			end
		end
	endtask
	task automatic t_dma(logic d, logic [3:0] c, logic u, logic [3:0] e);
		wr_reg(CTRL_OFFSET, cw(1'b0, 3'h0, d));
		@(posedge clk);
		cc <= c;
		upd <= u;
		@(posedge clk);
		cc <= 4'h0;
		upd <= 1'b0;
		@(negedge clk);
		chk("dma", {28'h0, e}, {28'h0, dma});
	endtask

	// =====================================
	// clock, sequence and watchdog
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		{rst_n, wr, rd, upd_gen, srst, run, pause, msm, upd} = '0;
		{addr, wdata, cc, cref, pins} = '0;
		repeat (6) @(posedge clk);
		chk("sync_trg", 32'h0, {31'h0, sync_trg});
		rst_n <= 1'b1;
		t_regs();
		t_pins();
		t_reset_sel();
		t_enable();
		t_upd_cc();
		t_compare();
		t_dma(1'b0, 4'hA, 1'b1, 4'hA);
		t_dma(1'b0, 4'h5, 1'b0, 4'h5);
		t_dma(1'b1, 4'hA, 1'b1, 4'hF);
		t_dma(1'b1, 4'h5, 1'b0, 4'h0);
		final_report();
	end
	// whole run is well under a thousand cycles
	initial begin
		repeat (4000) @(posedge clk);
		miscompares++;
		final_report();
	end
endmodule
